// ### sfp_packer.sv
// frame parameter packer, unpacker and per-subframe sequencer
//
// Overview of operation
// [R1] each frame is four 40-sample subframes; codebook fields in every subframe
// [R2] frame bit count depends only on mode: 95 to 244 bits
// [R3] every field goes out and comes in most significant bit first
// [R4] highest mode carries one joint 38-bit spectral field, others a single set
// [R5] 12.2: delay 9,6,9,6; pitch gain 4; code 35; gain 5; 244 bits
// [R6] 10.2: spectral 26; delay 8,5,8,5; code 31; joint gain 7; 204 bits
// [R7] 7.95: spectral 27; delay 8,6,8,6; gains 4 and 5; code 17; 159 bits
// [R8] 7.40: spectral 26; delay 8,5,8,5; code 17; joint gain 7; 148 bits
// [R9] 6.70: spectral 26; delay 8,4,8,4; code 14; joint gain 7; 134 bits
// [R10] 5.90: spectral 26; delay 8,4,8,4; code 11; joint gain 6; 118 bits
// [R11] 5.15: spectral 23; delay 8,4,4,4; code 9; joint gain 6; 103 bits
// [R12] 4.75: spectral 23; delay 8,4,4,4; code 9; 8-bit gain subframes 2,4 only
// [R13] spectral analysis twice per frame at 12.2, once otherwise
// [R14] open-loop pitch every second subframe, once per frame at 5.15 and 4.75
// [R15] closed-loop pitch at sixth-sample resolution in one mode, third otherwise
// [R16] gains scalar 4+5 bits or one joint 6-8 bit vector
// [R17] subframe steps: target, impulse, pitch, remove, codebook, gains, memories
// [R18] decoder extracts all fields by mode before decoding starts
// [R19] decoder converts spectra once and selects a filter per subframe
// [R20] decoder per subframe: excitation, synthesis, then postfilter
// [R21] one frame boundary every 160 sample strobes
// [R22] samples are 13 bits left justified in 16, low three bits zero
// [R23] spectral field first, subframes ascending; done strobe with mode tag
`timescale 1ns/100ps
`default_nettype none

module sfp_packer (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // sample timing and format
  input wire logic SAMPLE_STB_I,
  input wire logic [15:0] SAMPLE_I,
  input wire logic [2:0] ENC_MODE_I,
  output logic [15:0] SAMPLE_O,
  output logic FRAME_STB_O,
  output logic [1:0] SUBFRAME_O,
  // encoder schedule
  output logic LP_ANALYSIS_STB_O,
  output logic OL_PITCH_STB_O,
  output logic FRAC_SIXTH_O,
  output logic GAIN_SCALAR_O,
  output logic [6:0] ENC_STEP_O,
  // encoder parameters in
  input wire logic TX_LOAD_I,
  input wire logic [2:0] TX_MODE_I,
  input wire logic [37:0] TX_SPEC_I,
  input wire logic [35:0] TX_DELAY_I,
  input wire logic [15:0] TX_PGAIN_I,
  input wire logic [139:0] TX_CODE_I,
  input wire logic [31:0] TX_CGAIN_I,
  // serial frame out
  output logic TX_BUSY_O,
  output logic TX_BIT_O,
  output logic TX_VALID_O,
  output logic TX_FIRST_O,
  output logic TX_DONE_O,
  output logic [2:0] TX_MODE_O,
  // serial frame in
  input wire logic RX_BIT_I,
  input wire logic RX_VALID_I,
  input wire logic RX_FIRST_I,
  input wire logic [2:0] RX_MODE_I,
  // decoded parameters out
  output logic [37:0] RX_SPEC_O,
  output logic [35:0] RX_DELAY_O,
  output logic [15:0] RX_PGAIN_O,
  output logic [139:0] RX_CODE_O,
  output logic [31:0] RX_CGAIN_O,
  output logic RX_FRAME_O,
  output logic [2:0] RX_MODE_O,
  // decoder schedule
  output logic [3:0] DEC_STEP_O,
  output logic [1:0] DEC_SF_O
);

  // width of field f (0 spectral, then delay, pgain, code, gain per subframe)
  function automatic logic [5:0] fw(input logic [2:0] m, input logic [4:0] f);
    logic [4:0] g;
    logic [1:0] sf;
    g = f - 5'h01;
    sf = g[3:2];
    if (f == 5'h00) begin
      fw = sfp_pkg::SPEC_BITS[m]; // [R4]
    end else begin
      case (g[1:0])
        2'd0: fw = (sf == 2'd0 || (sf == 2'd2 && m > sfp_pkg::MODE_515)) ?
          sfp_pkg::DLY_EVEN_BITS[m] : sfp_pkg::DLY_ODD_BITS[m];
        2'd1: fw = sfp_pkg::PG_BITS[m]; // [R16]
        2'd2: fw = sfp_pkg::CODE_BITS[m]; // [R5] [R6] [R7] [R8] [R9] [R10] [R11] [R12]
        default: fw = (m == sfp_pkg::MODE_475 && !sf[0]) ? 6'h00 : sfp_pkg::CG_BITS[m]; // [R12]
      endcase
    end
  endfunction

  // next field after f, skipping empty slots (never two in a row)
  function automatic logic [4:0] nf(input logic [2:0] m, input logic [4:0] f);
    nf = (fw(m, f + 5'h01) == 6'h00) ? f + 5'h02 : f + 5'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // sample timing and schedule

  logic [7:0] scnt_q;
  logic [2:0] emode_q;
  logic sf_start;
  logic frame_end;
  logic [1:0] sf_next;
  logic lp_hit;
  logic ol_hit;
  sfp_pkg::sfp_enc_t estep_q;
  sfp_pkg::sfp_enc_t estep_d;

  assign frame_end = SAMPLE_STB_I && scnt_q == 8'(sfp_pkg::FRAME_SAMPLES - 1); // [R21]
  assign sf_start = SAMPLE_STB_I && (scnt_q % 8'(sfp_pkg::SF_SAMPLES)) == 8'(sfp_pkg::SF_SAMPLES - 1); // [R1]
  assign sf_next = frame_end ? 2'd0 : 2'(scnt_q / 8'(sfp_pkg::SF_SAMPLES) + 8'h01);
  // second analysis lands on subframe 2 only in the joint-spectrum mode
  assign lp_hit = sf_next == 2'd0 || (sf_next == 2'd2 && emode_q == sfp_pkg::MODE_122); // [R13]
  assign ol_hit = sf_next == 2'd0 || (sf_next == 2'd2 && emode_q > sfp_pkg::MODE_515); // [R14]

  always_comb begin
    case (estep_q)
      sfp_pkg::SFP_E_IDLE: estep_d = sf_start ? sfp_pkg::SFP_E_TARGET : sfp_pkg::SFP_E_IDLE;
      sfp_pkg::SFP_E_TARGET: estep_d = sfp_pkg::SFP_E_IMPULSE; // [R17]
      sfp_pkg::SFP_E_IMPULSE: estep_d = sfp_pkg::SFP_E_PITCH;
      sfp_pkg::SFP_E_PITCH: estep_d = sfp_pkg::SFP_E_REMOVE;
      sfp_pkg::SFP_E_REMOVE: estep_d = sfp_pkg::SFP_E_CODEBOOK;
      sfp_pkg::SFP_E_CODEBOOK: estep_d = sfp_pkg::SFP_E_GAIN;
      sfp_pkg::SFP_E_GAIN: estep_d = sfp_pkg::SFP_E_MEMORY;
      default: estep_d = sfp_pkg::SFP_E_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      scnt_q <= sfp_pkg::SAMPLE_CNT_RST;
      emode_q <= sfp_pkg::MODE_RST;
      estep_q <= sfp_pkg::SFP_E_IDLE;
      SAMPLE_O <= 16'h0000;
      FRAME_STB_O <= 1'b0;
      SUBFRAME_O <= 2'd0;
      LP_ANALYSIS_STB_O <= 1'b0;
      OL_PITCH_STB_O <= 1'b0;
      FRAC_SIXTH_O <= 1'b0;
      GAIN_SCALAR_O <= 1'b0;
      ENC_STEP_O <= 7'h00;
    end else begin
      estep_q <= estep_d;
      ENC_STEP_O <= 7'(estep_d >> 1);
      FRAME_STB_O <= frame_end;
      LP_ANALYSIS_STB_O <= sf_start && lp_hit;
      OL_PITCH_STB_O <= sf_start && ol_hit;
      if (SAMPLE_STB_I) begin
        scnt_q <= frame_end ? 8'h00 : scnt_q + 8'h01;
        SAMPLE_O <= {SAMPLE_I[15:3], 3'b000}; // [R22]
      end
      if (sf_start) begin
        SUBFRAME_O <= sf_next;
      end
      // mode only changes on a frame boundary
      if (frame_end) begin
        emode_q <= ENC_MODE_I;
        FRAC_SIXTH_O <= ENC_MODE_I == sfp_pkg::MODE_122; // [R15]
        GAIN_SCALAR_O <= ENC_MODE_I == sfp_pkg::MODE_122 || ENC_MODE_I == sfp_pkg::MODE_795; // [R16]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit: serialise one frame

  sfp_pkg::sfp_link_t tx_st_q;
  logic [2:0] tmode_q;
  logic [4:0] tfld_q;
  logic [5:0] tbit_q;
  logic [7:0] tcnt_q;
  logic [37:0] tspec_q;
  logic [35:0] tdly_q;
  logic [15:0] tpg_q;
  logic [139:0] tcode_q;
  logic [31:0] tcg_q;
  logic [4:0] tg;
  logic [37:0] tval;
  logic tx_last;
  logic tfld_end;

  assign tg = tfld_q - 5'h01;
  assign tval = (tfld_q == 5'h00) ? tspec_q :
    (tg[1:0] == 2'd0) ? 38'(tdly_q[tg[3:2] * sfp_pkg::DLY_W +: sfp_pkg::DLY_W]) :
    (tg[1:0] == 2'd1) ? 38'(tpg_q[tg[3:2] * sfp_pkg::PG_W +: sfp_pkg::PG_W]) :
    (tg[1:0] == 2'd2) ? 38'(tcode_q[tg[3:2] * sfp_pkg::CODE_W +: sfp_pkg::CODE_W]) :
    38'(tcg_q[tg[3:2] * sfp_pkg::CG_W +: sfp_pkg::CG_W]);
  assign tfld_end = tbit_q == 6'h00;
  assign tx_last = tcnt_q == sfp_pkg::FRAME_BITS[tmode_q] - 8'h01; // [R2]

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      tx_st_q <= sfp_pkg::SFP_LK_IDLE;
      tmode_q <= sfp_pkg::MODE_RST;
      tfld_q <= 5'h00;
      tbit_q <= 6'h00;
      tcnt_q <= 8'h00;
      tspec_q <= '0;
      tdly_q <= '0;
      tpg_q <= '0;
      tcode_q <= '0;
      tcg_q <= '0;
      TX_BUSY_O <= 1'b0;
      TX_BIT_O <= 1'b0;
      TX_VALID_O <= 1'b0;
      TX_FIRST_O <= 1'b0;
      TX_DONE_O <= 1'b0;
      TX_MODE_O <= sfp_pkg::MODE_RST;
    end else begin
      TX_VALID_O <= 1'b0;
      TX_FIRST_O <= 1'b0;
      TX_DONE_O <= 1'b0;
      case (tx_st_q)
        sfp_pkg::SFP_LK_IDLE: begin
          // loads while busy are ignored
          if (TX_LOAD_I) begin
            tx_st_q <= sfp_pkg::SFP_LK_RUN;
            tmode_q <= TX_MODE_I;
            tspec_q <= TX_SPEC_I;
            tdly_q <= TX_DELAY_I;
            tpg_q <= TX_PGAIN_I;
            tcode_q <= TX_CODE_I;
            tcg_q <= TX_CGAIN_I;
            tfld_q <= 5'h00; // [R23]
            tbit_q <= sfp_pkg::SPEC_BITS[TX_MODE_I] - 6'h01;
            tcnt_q <= 8'h00;
            TX_BUSY_O <= 1'b1;
          end
        end
        sfp_pkg::SFP_LK_RUN: begin
          TX_BIT_O <= tval[tbit_q]; // [R3]
          TX_VALID_O <= 1'b1;
          TX_FIRST_O <= tcnt_q == 8'h00;
          tcnt_q <= tcnt_q + 8'h01;
          if (tx_last) begin
            tx_st_q <= sfp_pkg::SFP_LK_IDLE;
            TX_BUSY_O <= 1'b0;
            TX_DONE_O <= 1'b1; // [R23]
            TX_MODE_O <= tmode_q;
          end else if (tfld_end) begin
            tfld_q <= nf(tmode_q, tfld_q); // [R23]
            tbit_q <= fw(tmode_q, nf(tmode_q, tfld_q)) - 6'h01;
          end else begin
            tbit_q <= tbit_q - 6'h01;
          end
        end
        default: tx_st_q <= sfp_pkg::SFP_LK_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive: extract fields, then run the decoder sequence

  logic [2:0] rmode_q;
  logic [4:0] rfld_q;
  logic [5:0] rbit_q;
  logic [7:0] rcnt_q;
  logic [37:0] racc_q;
  logic [37:0] racc_n;
  logic [2:0] rmode;
  logic [4:0] rfld;
  logic [5:0] rbit;
  logic [7:0] rcnt;
  logic [4:0] rg;
  logic rfld_done;
  logic rframe_done;
  sfp_pkg::sfp_dec_t dst_q;

  // the first bit restarts extraction, so a truncated frame is dropped
  assign rmode = RX_FIRST_I ? RX_MODE_I : rmode_q;
  assign rfld = RX_FIRST_I ? 5'h00 : rfld_q;
  assign rbit = RX_FIRST_I ? 6'h00 : rbit_q;
  assign rcnt = RX_FIRST_I ? 8'h00 : rcnt_q;
  assign racc_n = {(RX_FIRST_I ? 37'h0 : racc_q[36:0]), RX_BIT_I}; // [R3]
  assign rg = rfld - 5'h01;
  assign rfld_done = RX_VALID_I && rbit + 6'h01 == fw(rmode, rfld); // [R18]
  assign rframe_done = RX_VALID_I && rcnt + 8'h01 == sfp_pkg::FRAME_BITS[rmode]; // [R2]

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rmode_q <= sfp_pkg::MODE_RST;
      rfld_q <= 5'h00;
      rbit_q <= 6'h00;
      rcnt_q <= 8'h00;
      racc_q <= '0;
      RX_SPEC_O <= '0;
      RX_DELAY_O <= '0;
      RX_PGAIN_O <= '0;
      RX_CODE_O <= '0;
      RX_CGAIN_O <= '0;
      RX_FRAME_O <= 1'b0;
      RX_MODE_O <= sfp_pkg::MODE_RST;
    end else begin
      RX_FRAME_O <= 1'b0;
      if (RX_VALID_I) begin
        rmode_q <= rmode;
        rcnt_q <= rframe_done ? 8'h00 : rcnt + 8'h01;
        racc_q <= rfld_done ? 38'h0 : racc_n;
        rbit_q <= rfld_done ? 6'h00 : rbit + 6'h01;
        rfld_q <= rframe_done ? 5'h00 : rfld_done ? nf(rmode, rfld) : rfld;
        if (rfld_done) begin
          if (rfld == 5'h00) begin
            RX_SPEC_O <= racc_n;
          end else begin
            case (rg[1:0])
              2'd0: RX_DELAY_O[rg[3:2] * sfp_pkg::DLY_W +: sfp_pkg::DLY_W] <= racc_n[8:0];
              2'd1: RX_PGAIN_O[rg[3:2] * sfp_pkg::PG_W +: sfp_pkg::PG_W] <= racc_n[3:0];
              2'd2: RX_CODE_O[rg[3:2] * sfp_pkg::CODE_W +: sfp_pkg::CODE_W] <= racc_n[34:0];
              default: RX_CGAIN_O[rg[3:2] * sfp_pkg::CG_W +: sfp_pkg::CG_W] <= racc_n[7:0];
            endcase
          end
        end
        if (rframe_done) begin
          RX_FRAME_O <= 1'b1;
          RX_MODE_O <= rmode;
        end
      end
    end
  end

  // decoder: convert once, then excite, synthesise, postfilter per subframe
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      dst_q <= sfp_pkg::SFP_D_IDLE;
      DEC_STEP_O <= 4'h0;
      DEC_SF_O <= 2'd0;
    end else begin
      case (dst_q)
        sfp_pkg::SFP_D_IDLE: begin
          if (rframe_done) begin
            dst_q <= sfp_pkg::SFP_D_CONVERT; // [R18]
            DEC_STEP_O <= 4'h1;
            DEC_SF_O <= 2'd0;
          end else begin
            DEC_STEP_O <= 4'h0;
          end
        end
        sfp_pkg::SFP_D_CONVERT: begin
          dst_q <= sfp_pkg::SFP_D_EXCITE; // [R19]
          DEC_STEP_O <= 4'h2;
        end
        sfp_pkg::SFP_D_EXCITE: begin
          dst_q <= sfp_pkg::SFP_D_SYNTH; // [R20]
          DEC_STEP_O <= 4'h4;
        end
        sfp_pkg::SFP_D_SYNTH: begin
          dst_q <= sfp_pkg::SFP_D_POST;
          DEC_STEP_O <= 4'h8;
        end
        sfp_pkg::SFP_D_POST: begin
          if (DEC_SF_O == 2'(sfp_pkg::SF_PER_FRAME - 1)) begin
            dst_q <= sfp_pkg::SFP_D_IDLE;
            DEC_STEP_O <= 4'h0;
          end else begin
            dst_q <= sfp_pkg::SFP_D_EXCITE;
            DEC_STEP_O <= 4'h2;
            DEC_SF_O <= DEC_SF_O + 2'd1; // [R19]
          end
        end
        default: dst_q <= sfp_pkg::SFP_D_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// ### sfp_pkg.sv
// constants for the speech frame parameter packer
package sfp_pkg;
  // rate modes, 0 = 4.75 kbit/s up to 7 = 12.2 kbit/s
  localparam logic [2:0] MODE_475 = 3'h0;
  localparam logic [2:0] MODE_515 = 3'h1;
  localparam logic [2:0] MODE_795 = 3'h5;
  localparam logic [2:0] MODE_122 = 3'h7;
  // frame geometry
  localparam int SF_PER_FRAME = 4;
  localparam int SF_SAMPLES = 40;
  localparam int FRAME_SAMPLES = 160;
  localparam int FIELD_COUNT = 17;
  // field slot widths inside the packed subframe ports
  localparam int DLY_W = 9;
  localparam int PG_W = 4;
  localparam int CODE_W = 35;
  localparam int CG_W = 8;
  localparam int SPEC_W = 38;
  // per-mode widths, index is the mode code
  localparam logic [5:0] SPEC_BITS [8] = '{6'h17, 6'h17, 6'h1A, 6'h1A, 6'h1A, 6'h1B, 6'h1A, 6'h26};
  localparam logic [5:0] DLY_EVEN_BITS [8] = '{6'h08, 6'h08, 6'h08, 6'h08, 6'h08, 6'h08, 6'h08, 6'h09};
  localparam logic [5:0] DLY_ODD_BITS [8] = '{6'h04, 6'h04, 6'h04, 6'h04, 6'h05, 6'h06, 6'h05, 6'h06};
  localparam logic [5:0] PG_BITS [8] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h04, 6'h00, 6'h04};
  localparam logic [5:0] CODE_BITS [8] = '{6'h09, 6'h09, 6'h0B, 6'h0E, 6'h11, 6'h11, 6'h1F, 6'h23};
  localparam logic [5:0] CG_BITS [8] = '{6'h08, 6'h06, 6'h06, 6'h07, 6'h07, 6'h05, 6'h07, 6'h05};
  // frame totals: 95 103 118 134 148 159 204 244
  localparam logic [7:0] FRAME_BITS [8] = '{8'h5F, 8'h67, 8'h76, 8'h86, 8'h94, 8'h9F, 8'hCC, 8'hF4};
  // reset values
  localparam logic [7:0] SAMPLE_CNT_RST = 8'h00;
  localparam logic [2:0] MODE_RST = 3'h0;
  // transmit sequencer
  typedef enum logic [1:0] {
    SFP_LK_IDLE = 2'b01,
    SFP_LK_RUN = 2'b10
  } sfp_link_t;
  // per-subframe encoder steps
  typedef enum logic [7:0] {
    SFP_E_IDLE = 8'b0000_0001,
    SFP_E_TARGET = 8'b0000_0010,
    SFP_E_IMPULSE = 8'b0000_0100,
    SFP_E_PITCH = 8'b0000_1000,
    SFP_E_REMOVE = 8'b0001_0000,
    SFP_E_CODEBOOK = 8'b0010_0000,
    SFP_E_GAIN = 8'b0100_0000,
    SFP_E_MEMORY = 8'b1000_0000
  } sfp_enc_t;
  // decoder steps
  typedef enum logic [4:0] {
    SFP_D_IDLE = 5'b0_0001,
    SFP_D_CONVERT = 5'b0_0010,
    SFP_D_EXCITE = 5'b0_0100,
    SFP_D_SYNTH = 5'b0_1000,
    SFP_D_POST = 5'b1_0000
  } sfp_dec_t;
endpackage

// ### sfp_packer_properties.sv
// assertion checker for the frame parameter packer
`timescale 1ns/100ps
`default_nettype none
module sfp_packer_properties (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // samples and encoder schedule
  input wire logic SAMPLE_STB_I,
  input wire logic [15:0] SAMPLE_I,
  input wire logic [15:0] SAMPLE_O,
  input wire logic FRAME_STB_O,
  input wire logic [1:0] SUBFRAME_O,
  input wire logic LP_ANALYSIS_STB_O,
  input wire logic OL_PITCH_STB_O,
  input wire logic FRAC_SIXTH_O,
  input wire logic [6:0] ENC_STEP_O,
  // serial frames and decoder schedule
  input wire logic TX_LOAD_I,
  input wire logic TX_BUSY_O,
  input wire logic TX_VALID_O,
  input wire logic TX_FIRST_O,
  input wire logic TX_DONE_O,
  input wire logic [2:0] TX_MODE_O,
  input wire logic RX_FRAME_O,
  input wire logic [3:0] DEC_STEP_O,
  input wire logic [1:0] DEC_SF_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  logic [7:0] bits_q;
  // bits sent so far, restarted by the first bit
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      bits_q <= 8'h00;
    end else if (TX_VALID_O) begin
      bits_q <= TX_FIRST_O ? 8'h01 : bits_q + 8'h01;
    end
  end
  a_sample_justified: assert property (
    $past(SAMPLE_STB_I) |-> SAMPLE_O == ($past(SAMPLE_I) & 16'hFFF8)) else $error("sample word wrong");
  a_step_begin: assert property (
    SUBFRAME_O != $past(SUBFRAME_O) |-> ENC_STEP_O == 7'h01) else $error("steps not started");
  a_step_chain: assert property (
    ENC_STEP_O == 7'h01 |=> ENC_STEP_O == 7'h02 ##1 ENC_STEP_O == 7'h04 ##1 ENC_STEP_O == 7'h08
    ##1 ENC_STEP_O == 7'h10 ##1 ENC_STEP_O == 7'h20 ##1 ENC_STEP_O == 7'h40 ##1 ENC_STEP_O == 7'h00)
    else $error("step order broken");
  a_frame_start: assert property (
    FRAME_STB_O |-> SUBFRAME_O == 2'h0 && LP_ANALYSIS_STB_O && OL_PITCH_STB_O) else $error("frame start");
  a_lp_second: assert property (
    LP_ANALYSIS_STB_O && !FRAME_STB_O |-> FRAC_SIXTH_O && SUBFRAME_O == 2'h2) else $error("extra analysis");
  a_ol_even: assert property (
    OL_PITCH_STB_O |-> !SUBFRAME_O[0] && SUBFRAME_O != $past(SUBFRAME_O)) else $error("pitch estimate slot");
  a_tx_start: assert property (
    TX_LOAD_I && !TX_BUSY_O |=> TX_BUSY_O ##1 TX_VALID_O && TX_FIRST_O) else $error("frame start late");
  a_tx_count: assert property (
    TX_DONE_O |-> bits_q + 8'h01 == sfp_pkg::FRAME_BITS[TX_MODE_O]) else $error("frame length wrong");
  a_tx_gapless: assert property (
    TX_VALID_O && !TX_DONE_O |=> TX_VALID_O) else $error("gap in frame");
  a_done_free: assert property (
    TX_DONE_O |-> TX_VALID_O && !TX_BUSY_O) else $error("done without last bit");
  a_dec_chain: assert property (
    DEC_STEP_O == 4'h2 |=> DEC_STEP_O == 4'h4 ##1 DEC_STEP_O == 4'h8) else $error("decoder order");
  a_dec_start: assert property (
    RX_FRAME_O |-> DEC_STEP_O == 4'h1 && DEC_SF_O == 2'h0) else $error("decoder start");
  c_tx_top: cover property (TX_DONE_O && TX_MODE_O == 3'h7);
  c_rx_frame: cover property (RX_FRAME_O);
  c_lp_twice: cover property (LP_ANALYSIS_STB_O && SUBFRAME_O == 2'h2);
endmodule
////////////////////////////////////////
bind sfp_packer sfp_packer_properties i_props (.CLK_I, .RESET_I, .SAMPLE_STB_I, .SAMPLE_I, .SAMPLE_O,
  .FRAME_STB_O, .SUBFRAME_O, .LP_ANALYSIS_STB_O, .OL_PITCH_STB_O, .FRAC_SIXTH_O, .ENC_STEP_O, .TX_LOAD_I,
  .TX_BUSY_O, .TX_VALID_O, .TX_FIRST_O, .TX_DONE_O, .TX_MODE_O, .RX_FRAME_O, .DEC_STEP_O, .DEC_SF_O);
`default_nettype wire

// ### sfp_chan_model.sv
// loopback channel: serial frame out comes back on the receive side
`timescale 1ns/100ps
`default_nettype none
module sfp_chan_model (
  // clock, reset and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic [2:0] mode_i,
  // transmit side of the packer
  input wire logic tx_bit_i,
  input wire logic tx_valid_i,
  input wire logic tx_first_i,
  // receive side of the packer
  output logic rx_bit_o = 1'b0,
  output logic rx_valid_o = 1'b0,
  output logic rx_first_o = 1'b0,
  output logic [2:0] rx_mode_o
);
  logic [1:0] q[$];
  logic [1:0] hd;
  assign rx_mode_o = mode_i;
  always @(posedge clk_i) begin
    if (tx_valid_i) begin
      q.push_back({tx_first_i, tx_bit_i});
    end
    rx_valid_o <= 1'b0;
    rx_first_o <= 1'b0;
    // idle line toggles so a stale bit never looks valid
    rx_bit_o <= ~rx_bit_o;
    if (rst_i) begin
      q.delete();
      rx_bit_o <= 1'b0;
    end else if (!stall_i && q.size() != 0) begin
      hd = q.pop_front();
      rx_valid_o <= 1'b1;
      rx_first_o <= hd[1];
      rx_bit_o <= hd[0];
    end
  end
endmodule
`default_nettype wire

// ### speech_frame_parameter_packer_tb.sv
// self-checking bench for the frame parameter packer
`timescale 1ns/100ps
`default_nettype none
module speech_frame_parameter_packer_tb;
  logic CLK_I, RESET_I, SAMPLE_STB_I, FRAME_STB_O, LP_ANALYSIS_STB_O, OL_PITCH_STB_O, FRAC_SIXTH_O;
  logic GAIN_SCALAR_O, TX_LOAD_I, TX_BUSY_O, TX_BIT_O, TX_VALID_O, TX_FIRST_O, TX_DONE_O;
  logic RX_BIT_I, RX_VALID_I, RX_FIRST_I, RX_FRAME_O, stall, slow;
  logic [1:0] SUBFRAME_O, DEC_SF_O;
  logic [2:0] ENC_MODE_I, TX_MODE_I, TX_MODE_O, RX_MODE_I, RX_MODE_O, rxm;
  logic [3:0] DEC_STEP_O;
  logic [6:0] ENC_STEP_O;
  logic [15:0] SAMPLE_I, SAMPLE_O, TX_PGAIN_I, RX_PGAIN_O;
  logic [31:0] TX_CGAIN_I, RX_CGAIN_O;
  logic [35:0] TX_DELAY_I, RX_DELAY_O;
  logic [37:0] TX_SPEC_I, RX_SPEC_O;
  logic [139:0] TX_CODE_I, RX_CODE_O;
  logic [261:0] txv, msk, rxv;
  logic [2:0] got_q[$];
  bit exp_q[$];
  int err_total, checked, cyc, lp_n, ol_n, fr_n, rx_n, lp0, ol0, fr0, dec_n, ds_n;
  int spw[8] = '{23, 23, 26, 26, 26, 27, 26, 38};
  int dlo[8] = '{4, 4, 4, 4, 5, 6, 5, 6};
  int pgw[8] = '{0, 0, 0, 0, 0, 4, 0, 4};
  int cdw[8] = '{9, 9, 11, 14, 17, 17, 31, 35};
  int cgw[8] = '{8, 6, 6, 7, 7, 5, 7, 5};
  int tot[8] = '{95, 103, 118, 134, 148, 159, 204, 244};
  int base[4] = '{38, 74, 90, 230};
  int strd[4] = '{9, 4, 35, 8};
  sfp_packer i_sfp_packer (.*);
  sfp_chan_model i_sfp_chan_model (.clk_i(CLK_I), .rst_i(RESET_I), .stall_i(stall), .mode_i(TX_MODE_I),
    .tx_bit_i(TX_BIT_O), .tx_valid_i(TX_VALID_O), .tx_first_i(TX_FIRST_O), .rx_bit_o(RX_BIT_I),
    .rx_valid_o(RX_VALID_I), .rx_first_o(RX_FIRST_I), .rx_mode_o(RX_MODE_I));
  initial begin
    CLK_I = 1'b0;
    forever #25 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I) begin
    cyc <= cyc + 1;
    lp_n <= lp_n + LP_ANALYSIS_STB_O;
    ol_n <= ol_n + OL_PITCH_STB_O;
    fr_n <= fr_n + FRAME_STB_O;
    // postfilter steps over all frames, and how many of them land on the last subframe
    dec_n <= dec_n + (DEC_STEP_O === 4'h8);
    ds_n <= ds_n + (DEC_STEP_O === 4'h8 && DEC_SF_O === 2'd3);
    stall <= slow && ($urandom % 3 == 0);
    if (TX_VALID_O === 1'b1) begin
      got_q.push_back({TX_FIRST_O, TX_DONE_O, TX_BIT_O});
    end
    if (RX_FRAME_O === 1'b1) begin
      rxv <= {RX_CGAIN_O, RX_CODE_O, RX_PGAIN_O, RX_DELAY_O, RX_SPEC_O};
      rxm <= RX_MODE_O;
      rx_n <= rx_n + 1;
    end
    if (cyc == 30000) begin
      err_total++;
      close_out();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [261:0] seen, input logic [261:0] want);
    checked++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic int fw(int m, int k, int f);
    case (f)
      0: return (k == 0 || (k == 2 && m > 1)) ? 8 + (m == 7) : dlo[m];
      1: return pgw[m];
      2: return cdw[m];
      default: return (m == 0 && !k[0]) ? 0 : cgw[m];
    endcase
  endfunction
  // random field bits, most significant first into the expected stream
  task automatic put(int off, int n);
    bit b;
    for (int i = n - 1; i >= 0; i--) begin
      b = $urandom;
      txv[off + i] = b;
      msk[off + i] = 1'b1;
      exp_q.push_back(b);
    end
  endtask
  task automatic frame(int m);
    logic [15:0] s;
    ENC_MODE_I <= m[2:0];
    repeat (160) begin
      s = $urandom;
      SAMPLE_I <= s;
      SAMPLE_STB_I <= 1'b1;
      @(posedge CLK_I);
      SAMPLE_STB_I <= 1'b0;
      @(posedge CLK_I);
      chk(SAMPLE_O, {s[15:3], 3'b000});
    end
  endtask
  task automatic tx_frame(int m);
    int r0;
    txv = '0;
    msk = '0;
    exp_q.delete();
    got_q.delete();
    r0 = rx_n;
    put(0, spw[m]);
    for (int k = 0; k < 4; k++) begin
      for (int f = 0; f < 4; f++) begin
        put(base[f] + strd[f] * k, fw(m, k, f));
      end
    end
    TX_MODE_I <= m[2:0];
    {TX_CGAIN_I, TX_CODE_I, TX_PGAIN_I, TX_DELAY_I, TX_SPEC_I} <= txv;
    TX_LOAD_I <= 1'b1;
    @(posedge CLK_I);
    // second load while busy must be ignored
    TX_SPEC_I <= ~txv[37:0];
    @(posedge CLK_I);
    TX_LOAD_I <= 1'b0;
    for (int n = 0; n < 900 && rx_n == r0; n++) @(posedge CLK_I);
    @(negedge CLK_I);
    // a frame that never comes back is a failure of its own
    if (rx_n == r0) begin
      err_total++;
    end
    chk(got_q.size(), tot[m]);
    foreach (exp_q[i]) chk(got_q[i], {i == 0, i == tot[m] - 1, exp_q[i]});
    chk(TX_MODE_O, m);
    chk(rxv & msk, txv);
    chk(rxm, m);
    @(posedge CLK_I);
  endtask
  initial begin
    void'($urandom(32'h2F77));
    RESET_I = 1'b1;
    SAMPLE_STB_I = 1'b0;
    SAMPLE_I = '0;
    ENC_MODE_I = '0;
    TX_LOAD_I = 1'b0;
    TX_MODE_I = '0;
    {TX_CGAIN_I, TX_CODE_I, TX_PGAIN_I, TX_DELAY_I, TX_SPEC_I} = '0;
    slow = 1'b0;
    repeat (20) @(posedge CLK_I);
    RESET_I <= 1'b0;
    @(posedge CLK_I);
    @(negedge CLK_I);
    chk({TX_BUSY_O, TX_VALID_O, FRAME_STB_O, SUBFRAME_O, ENC_STEP_O, DEC_STEP_O, RX_FRAME_O}, 0);
    @(posedge CLK_I);
    for (int m = 0; m < 8; m++) begin
      frame(m);
      @(negedge CLK_I);
      lp0 = lp_n;
      ol0 = ol_n;
      fr0 = fr_n;
      @(posedge CLK_I);
      frame(m);
      @(negedge CLK_I);
      chk(lp_n - lp0, 1 + (m == 7));
      chk(ol_n - ol0, 1 + (m > 1));
      chk(fr_n - fr0, 1);
      chk({SUBFRAME_O, ENC_STEP_O}, {2'd0, 7'h02});
      chk({FRAC_SIXTH_O, GAIN_SCALAR_O}, {m == 7, m == 7 || m == 5});
      @(posedge CLK_I);
      $display("schedule test mode %0d ended", m);
    end
    for (int m = 0; m < 8; m++) begin
      slow = m[0];
      tx_frame(m);
      $display("frame test mode %0d ended", m);
    end
    repeat (20) @(posedge CLK_I);
    @(negedge CLK_I);
    chk(dec_n, 32);
    chk(ds_n, 8);
    close_out();
  end
endmodule
`default_nettype wire
